// File: mapper_pkg.sv
// shared constants for the program/data space mapper
package mapper_pkg;
  localparam int PA_W = 24;                      // program address width
  localparam int PC_W = 23;                      // program counter width
  localparam int EA_W = 16;                      // data effective address width
  localparam int DW = 16;                        // data word width
  localparam int PW = 24;                        // program word width
  localparam int PAGE_W = 8;                     // page register width
  localparam int WIN_LSB = 15;                   // window offset bits from the data address
  localparam int CFG_BIT = 7;                    // table page bit selecting config space
  localparam int HI_BIT = 23;                    // address bit reaching id and config
  localparam int EA_MSB = 15;                    // data address msb, window select
  localparam logic [PA_W-1:0] USER_TOP = 24'h7FFFFE; // last user word address
  localparam logic [1:0] XW_NONE = 2'h0;         // extra window cycles: none
  localparam logic [1:0] XW_ONE = 2'h1;          // one extra cycle
  localparam logic [1:0] XW_TWO = 2'h2;          // two extra cycles
  localparam logic [DW-1:0] ZERO_WORD = 16'h0000; // answer for invalid access
  localparam logic [PA_W-1:0] PC_STEP = 24'h000002; // address step per program word
  // access kinds presented by the core, gray along fetch->table->data
  typedef enum logic [2:0] {
    ACC_FETCH = 3'h0,
    ACC_TRD_LO = 3'h1,
    ACC_TRD_HI = 3'h3,
    ACC_TWR_LO = 3'h2,
    ACC_TWR_HI = 3'h6,
    ACC_DATA = 3'h7
  } acc_kind_t;
  // extra-cycle sequencer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_STALL1 = 2'h1,
    ST_STALL2 = 2'h3
  } stall_st_t;
endpackage : mapper_pkg

// File: lane_steer.sv
// table-read and window lane steering from a program word to the data bus
`timescale 1ns/1ps
module lane_steer
  import mapper_pkg::*;
(
  input wire logic [PW-1:0] pword,   // fetched program word
  input wire logic high_sel,         // high (upper byte) side selected
  input wire logic byte_op,          // byte-sized access
  input wire logic byte_sel,         // byte select, lsb of the address
  output logic [DW-1:0] dout         // steered data value
);
  // lanes: low word, low bytes, upper byte or zero
  always_comb begin
    dout = ZERO_WORD;
    if (!high_sel) begin
      if (!byte_op)
        dout = pword[15:0];
      else if (!byte_sel)
        dout = {8'h00, pword[7:0]};
      else
        dout = {8'h00, pword[15:8]};
    end else begin
      if (!byte_op)
        dout = {8'h00, pword[23:16]};
      else if (!byte_sel)
        dout = {8'h00, pword[23:16]};
      else
        dout = ZERO_WORD;
    end
  end
endmodule : lane_steer

// File: program_data_space_mapper.sv
// program/data space address mapper with table lanes and window stalls
`timescale 1ns/1ps
module program_data_space_mapper
  import mapper_pkg::*;
#(
  parameter logic [EA_W-1:0] Y_BASE = 16'h0800,   // first y block byte address
  parameter logic [EA_W-1:0] Y_END = 16'h0BFE,    // last y block word address
  parameter logic [EA_W-1:0] RAM_END = 16'h0BFE   // last implemented data word
) (
  input wire logic clk,                        // 200 MHz core clock
  input wire logic resetn,                     // async reset, active low
  input wire logic ce,                         // clock enable, freezes state
  input wire logic req,                        // access request strobe
  input wire acc_kind_t kind,                  // access kind
  input wire logic byte_op,                    // byte-sized table access
  input wire logic [PC_W-1:0] pc,              // program counter
  input wire logic [EA_W-1:0] ea,              // data effective address
  input wire logic [PAGE_W-1:0] table_page_register,      // table page
  input wire logic [PAGE_W-1:0] visibility_page_register, // window page
  input wire logic visibility_enable,          // core control window enable
  input wire logic cls_short,                  // mac prefetch, move or double move
  input wire logic in_repeat,                  // executing inside a repeat loop
  input wire logic rpt_edge,                   // first/last iteration or irq exit/entry
  input wire logic mac_class,                  // multiply-accumulate class read
  input wire logic [EA_W-1:0] x_ea,            // mac x operand address
  input wire logic x_ptr_ok,                   // x operand from x_pointer_a/b
  input wire logic [EA_W-1:0] y_ea,            // mac y operand address
  input wire logic y_ptr_ok,                   // y operand from y_pointer_a/b
  input wire logic [PW-1:0] pword,             // program word from memory
  input wire logic [DW-1:0] x_rdata,           // x bus data from data memory
  input wire logic [DW-1:0] y_rdata,           // y bus data from data memory
  input wire logic [DW-1:0] wdata,             // table write data
  output logic [PA_W-1:0] paddr,               // program memory address
  output logic paddr_v,                        // program address valid
  output logic [DW-1:0] rdata,                 // data returned to core
  output logic rdata_v,                        // returned data valid
  output logic [DW-1:0] x_out,                 // mac x operand
  output logic [DW-1:0] y_out,                 // mac y operand
  output logic y_read,                         // concurrent y read active
  output logic stall,                          // extra window cycle in progress
  output logic fw_req,                         // table write to flash unit
  output logic fw_high,                        // write targets upper byte side
  output logic [PA_W-1:0] fw_addr,             // flash write address
  output logic [DW-1:0] fw_data,               // flash write data
  output logic addr_err                        // user access beyond user range
);

  // parameter sanity: y block must sit inside the implemented space
  if (Y_END < Y_BASE || RAM_END < Y_END || Y_BASE[0] != 1'b0)
    $error("y block must be aligned and lie inside implemented data space");

  // window selection and table classification
  function automatic logic is_table(input acc_kind_t k);
    is_table = (k == ACC_TRD_LO) || (k == ACC_TRD_HI) || (k == ACC_TWR_LO) ||
               (k == ACC_TWR_HI);
  endfunction : is_table

  function automatic logic in_y(input logic [EA_W-1:0] a);
    in_y = (a >= Y_BASE) && (a <= (Y_END | 16'h0001));
  endfunction : in_y

  logic win_hit;
  logic [PA_W-1:0] addr_nxt;
  logic [DW-1:0] steered;
  logic cfg_sp;
  logic addr_err_nxt;

  // windowing off while a table op runs; kind must be a data access
  assign win_hit = (kind == ACC_DATA) && ea[EA_MSB] && visibility_enable;
  assign cfg_sp = table_page_register[CFG_BIT];

  // address construction per access type
  always_comb begin
    addr_nxt = '0;
    case (kind)
      ACC_FETCH:
        addr_nxt = {1'b0, pc[PC_W-1:1], 1'b0};
      ACC_TRD_LO, ACC_TRD_HI, ACC_TWR_LO, ACC_TWR_HI:
        addr_nxt = {table_page_register, ea};
      ACC_DATA:
        addr_nxt = {1'b0, visibility_page_register, ea[WIN_LSB-1:0]};
      default:
        addr_nxt = '0;
    endcase
  end

  // fetch or window past the last user word is flagged; compared by word so
  // an odd byte inside the top word stays legal, and plain data never counts
  assign addr_err_nxt = req && (kind == ACC_FETCH || win_hit) &&
                        (addr_nxt[PA_W-1:1] > USER_TOP[PA_W-1:1]);

  lane_steer u_lane (
    .pword(pword),
    .high_sel(kind == ACC_TRD_HI),
    .byte_op(byte_op && is_table(kind)),
    .byte_sel(ea[0]),
    .dout(steered)
  );

  // extra-cycle count for window users; repeat edges cost two
  logic [1:0] xcyc;
  always_comb begin
    if (!in_repeat)
      xcyc = cls_short ? XW_ONE : XW_TWO;
    else
      xcyc = rpt_edge ? XW_TWO : XW_ONE;
  end

  stall_st_t st_r, st_nxt;
  logic go;
  assign go = req && win_hit && (st_r == ST_IDLE);

  // sequencer next state
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      ST_IDLE:   if (go) st_nxt = (xcyc == XW_TWO) ? ST_STALL2 : ST_STALL1;
      ST_STALL2: st_nxt = ST_STALL1;
      ST_STALL1: st_nxt = ST_IDLE;
      default:   st_nxt = ST_IDLE;
    endcase
  end

  // sequencer register; second program fetch hides under the stall
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) st_r <= ST_IDLE;
    else if (ce) st_r <= st_nxt;
  end

  // stall output registered from the next state
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) stall <= 1'b0;
    else if (ce) stall <= (st_nxt != ST_IDLE);
  end

  // program address and error flag
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      paddr <= '0;
      paddr_v <= 1'b0;
      addr_err <= 1'b0;
    end else if (ce) begin
      paddr_v <= req && (kind != ACC_DATA || win_hit) && !addr_err_nxt;
      addr_err <= addr_err_nxt;
      if (req) paddr <= addr_err_nxt ? '0 : addr_nxt;
    end
  end

  // single data return: table lanes, window low word, or plain data
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdata <= ZERO_WORD;
      rdata_v <= 1'b0;
    end else if (ce) begin
      rdata_v <= req && (kind == ACC_TRD_LO || kind == ACC_TRD_HI || kind == ACC_DATA);
      if (req && (kind == ACC_TRD_LO || kind == ACC_TRD_HI))
        rdata <= steered;
      else if (req && win_hit)
        rdata <= pword[DW-1:0];
      else if (req && kind == ACC_DATA)
        rdata <= (ea > (RAM_END | 16'h0001)) ? ZERO_WORD : x_rdata;
    end
  end

  // mac dual read: x excludes y block, y only via y pointers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      x_out <= ZERO_WORD;
      y_out <= ZERO_WORD;
      y_read <= 1'b0;
    end else if (ce) begin
      y_read <= req && mac_class;
      if (req && mac_class) begin
        x_out <= (x_ptr_ok && !in_y(x_ea) && x_ea <= (RAM_END | 16'h0001))
                 ? x_rdata : ZERO_WORD;
        y_out <= (y_ptr_ok && in_y(y_ea)) ? y_rdata : ZERO_WORD;
      end
    end
  end

  // table writes handed to the flash programming unit
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      fw_req <= 1'b0;
      fw_high <= 1'b0;
      fw_addr <= '0;
      fw_data <= ZERO_WORD;
    end else if (ce) begin
      fw_req <= req && (kind == ACC_TWR_LO || kind == ACC_TWR_HI);
      if (req && (kind == ACC_TWR_LO || kind == ACC_TWR_HI)) begin
        fw_high <= (kind == ACC_TWR_HI);
        fw_addr <= addr_nxt;
        fw_data <= wdata;
      end
    end
  end

  // checks
  sequence win_req_s;
    req && ce && win_hit && st_r == ST_IDLE;
  endsequence
  property win_two_p;
    @(posedge clk) disable iff (!resetn)
      win_req_s and (xcyc == XW_TWO) |=> stall ##1 (!ce || stall);
  endproperty

  // fetch address: pc bits, even, never above user space
  fetch_bit23_a: assert property (@(posedge clk) disable iff (!resetn)
    req && ce && kind == ACC_FETCH |=> !paddr[HI_BIT])
    else $error("fetch set bit 23");
  fetch_addr_a: assert property (@(posedge clk) disable iff (!resetn)
    req && ce && kind == ACC_FETCH |=> paddr[PC_W-1:1] == $past(pc[PC_W-1:1]))
    else $error("fetch address wrong");
  fetch_step_a: assert property (@(posedge clk) disable iff (!resetn)
    req && ce && kind == ACC_FETCH |=> !paddr[0])
    else $error("fetch address odd");

  // window: page from the visibility page, low word only, off when disabled
  win_page_a: assert property (@(posedge clk) disable iff (!resetn)
    req && ce && win_hit |=> paddr[PA_W-2:WIN_LSB] == $past(visibility_page_register))
    else $error("window page wrong");
  win_cfg_a: assert property (@(posedge clk) disable iff (!resetn)
    req && ce && win_hit |=> !paddr[HI_BIT])
    else $error("window reached config");
  win_low_a: assert property (@(posedge clk) disable iff (!resetn)
    req && ce && win_hit |=> rdata == $past(pword[DW-1:0]))
    else $error("window data not low word");
  win_off_a: assert property (@(posedge clk) disable iff (!resetn)
    req && ce && kind == ACC_DATA && !visibility_enable |=> !paddr_v)
    else $error("window used while disabled");

  // table accesses: page bit picks the space, lanes per kind and byte select
  tbl_space_a: assert property (@(posedge clk) disable iff (!resetn)
    req && ce && is_table(kind) && kind != ACC_TWR_LO && kind != ACC_TWR_HI
    |=> paddr[HI_BIT] == $past(cfg_sp)) else $error("table space bit wrong");
  tbl_addr_a: assert property (@(posedge clk) disable iff (!resetn)
    req && ce && is_table(kind) |=> paddr == {$past(table_page_register), $past(ea)})
    else $error("table address wrong");
  tbl_nowin_a: assert property (@(posedge clk) disable iff (!resetn)
    req && ce && is_table(kind) && st_r == ST_IDLE |=> !stall)
    else $error("table access started a stall");
  trdh_zero_a: assert property (@(posedge clk) disable iff (!resetn)
    req && ce && kind == ACC_TRD_HI |=> rdata[15:8] == 8'h00)
    else $error("high byte nonzero");
  trdh_byte_a: assert property (@(posedge clk) disable iff (!resetn)
    req && ce && kind == ACC_TRD_HI && byte_op && ea[0] |=> rdata == ZERO_WORD)
    else $error("high odd byte nonzero");
  trdl_word_a: assert property (@(posedge clk) disable iff (!resetn)
    req && ce && kind == ACC_TRD_LO && !byte_op |=> rdata == $past(pword[15:0]))
    else $error("low word wrong");
  trdl_byte_a: assert property (@(posedge clk) disable iff (!resetn)
    req && ce && kind == ACC_TRD_LO && byte_op |=> rdata[15:8] == 8'h00)
    else $error("low byte not in low lane");

  // extra window cycles; a frozen edge must not advance anything
  win_stall_a: assert property (win_two_p)
    else $error("two-cycle stall missing");
  win_one_a: assert property (@(posedge clk) disable iff (!resetn)
    win_req_s and (xcyc == XW_ONE) |=> stall ##1 ($past(ce) -> !stall))
    else $error("one-cycle stall wrong");
  stall_max_a: assert property (@(posedge clk) disable iff (!resetn)
    stall && ce ##1 stall && ce |=> !stall)
    else $error("stall longer than two");
  ce_hold_a: assert property (@(posedge clk) disable iff (!resetn)
    !ce |=> $stable(paddr) && $stable(paddr_v) && $stable(rdata) && $stable(stall))
    else $error("state moved while frozen");

  // dual read partition and invalid addresses
  mac_y_a: assert property (@(posedge clk) disable iff (!resetn)
    req && ce && mac_class && !y_ptr_ok |=> y_out == ZERO_WORD)
    else $error("y read by x pointer");
  mac_y_ok_a: assert property (@(posedge clk) disable iff (!resetn)
    req && ce && mac_class && y_ptr_ok && in_y(y_ea) |=> y_out == $past(y_rdata))
    else $error("y operand lost");
  mac_x_a: assert property (@(posedge clk) disable iff (!resetn)
    req && ce && mac_class && in_y(x_ea) |=> x_out == ZERO_WORD)
    else $error("x read reached y block");
  y_pulse_a: assert property (@(posedge clk) disable iff (!resetn)
    req && ce && !mac_class |=> !y_read)
    else $error("y read outside mac");
  data_zero_a: assert property (@(posedge clk) disable iff (!resetn)
    req && ce && kind == ACC_DATA && !win_hit && ea > (RAM_END | 16'h0001) |=> rdata == ZERO_WORD)
    else $error("unimplemented read nonzero");

  // table writes reach the flash unit intact
  fw_fwd_a: assert property (@(posedge clk) disable iff (!resetn)
    req && ce && kind == ACC_TWR_HI |=> fw_req && fw_high)
    else $error("table write lost");
  fw_low_a: assert property (@(posedge clk) disable iff (!resetn)
    req && ce && kind == ACC_TWR_LO |=> fw_req && !fw_high)
    else $error("low table write lost");
  fw_data_a: assert property (@(posedge clk) disable iff (!resetn)
    req && ce && (kind == ACC_TWR_LO || kind == ACC_TWR_HI) |=> fw_data == $past(wdata))
    else $error("table write data wrong");
endmodule : program_data_space_mapper

// File: mapper_core_model.sv
// core-side memory model feeding program words and data words
`timescale 1ns/1ps
module mapper_core_model
  import mapper_pkg::*;
(
  input wire logic [PA_W-1:0] addr, // program address being read
  input wire logic [7:0] salt,      // varies the upper program byte
  input wire logic [EA_W-1:0] ea,   // x side data address
  input wire logic [EA_W-1:0] y_ea, // y side data address
  output logic [PW-1:0] pword,      // program word at addr
  output logic [DW-1:0] x_rdata,    // x bus word
  output logic [DW-1:0] y_rdata     // y bus word
);
  // address-dependent patterns, so a wrong address or lane shows up
  assign pword = {addr[15:8] ^ salt, addr[15:0] ^ {addr[23:16], 8'hA5}};
  assign x_rdata = ea ^ 16'h3C96;
  assign y_rdata = y_ea ^ 16'h69C3;
endmodule : mapper_core_model

// File: test_program_data_space_mapper.sv
// self-checking bench for the program/data space mapper
`timescale 1ns/1ps
module test_program_data_space_mapper;
  import mapper_pkg::*;
  localparam logic [EA_W-1:0] Y_BASE = 16'h0800;  // first y block byte
  localparam logic [EA_W-1:0] Y_END = 16'h0BFE;   // last y block word
  localparam logic [EA_W-1:0] RAM_END = 16'h0BFE; // last implemented word
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic ce = 1'b1;
  logic req = 1'b0;
  acc_kind_t kind = ACC_FETCH;
  logic byte_op = 1'b0;
  logic [PC_W-1:0] pc = '0;
  logic [EA_W-1:0] ea = '0;
  logic [7:0] tpage = '0;
  logic [7:0] vpage = '0;
  logic ve = 1'b0;
  logic sh = 1'b0;
  logic rep = 1'b0;
  logic edg = 1'b0;
  logic mac = 1'b0;
  logic [EA_W-1:0] x_ea = '0;
  logic xok = 1'b0;
  logic [EA_W-1:0] y_ea = '0;
  logic yok = 1'b0;
  logic [DW-1:0] wdata = '0;
  logic [PA_W-1:0] maddr = '0;
  logic [7:0] salt = '0;
  logic [EA_W-1:0] mea;
  logic [PW-1:0] pword;
  logic [DW-1:0] x_rdata, y_rdata, rdata, x_out, y_out, fw_data;
  logic [PA_W-1:0] paddr, fw_addr;
  logic paddr_v, rdata_v, y_read, stall, fw_req, fw_high, addr_err;
  int errors = 0;
  int n_checks = 0;
  int cycles = 0;
  logic [31:0] rnd = 32'h4639;
  acc_kind_t kinds [6] = '{ACC_FETCH, ACC_TRD_LO, ACC_TRD_HI, ACC_TWR_LO, ACC_TWR_HI, ACC_DATA};

  always #2.5 clk = ~clk;
  assign mea = mac ? x_ea : ea; // x side address seen by memory

  program_data_space_mapper #(.Y_BASE(Y_BASE), .Y_END(Y_END), .RAM_END(RAM_END)) dut_u (
    .clk(clk), .resetn(resetn), .ce(ce), .req(req), .kind(kind),
    .byte_op(byte_op), .pc(pc), .ea(ea), .table_page_register(tpage),
    .visibility_page_register(vpage), .visibility_enable(ve), .cls_short(sh), .in_repeat(rep),
    .rpt_edge(edg), .mac_class(mac), .x_ea(x_ea), .x_ptr_ok(xok), .y_ea(y_ea), .y_ptr_ok(yok),
    .pword(pword), .x_rdata(x_rdata), .y_rdata(y_rdata), .wdata(wdata), .paddr(paddr),
    .paddr_v(paddr_v), .rdata(rdata), .rdata_v(rdata_v), .x_out(x_out), .y_out(y_out),
    .y_read(y_read), .stall(stall), .fw_req(fw_req), .fw_high(fw_high), .fw_addr(fw_addr),
    .fw_data(fw_data), .addr_err(addr_err));
  mapper_core_model mem_u (.addr(maddr), .salt(salt), .ea(mea), .y_ea(y_ea), .pword(pword),
    .x_rdata(x_rdata), .y_rdata(y_rdata));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  // expected data lane of a table read
  function automatic logic [15:0] lane(input logic hi, input logic b, input logic sel,
                                       input logic [23:0] w);
    if (hi) return (b && sel) ? 16'h0000 : {8'h00, w[23:16]};
    if (b) return {8'h00, sel ? w[15:8] : w[7:0]};
    return w[15:0];
  endfunction : lane

  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH t=%0t seen=%06h exp=%06h", $time, seen, exp);
    end
  endtask : chk

  task automatic end_of_test();
    $display("checks=%0d errors=%0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test

  // one random request of kind k, then every port checked against the rules
  task automatic run_one(input acc_kind_t k, input logic m, input logic corner);
    logic [31:0] r2;
    logic win, tw, tr;
    int n;
    rnd = lfsr(rnd);
    r2 = lfsr(rnd ^ 32'h5A5A0F0F);
    @(posedge clk);
    #1;
    req = 1'b1; kind = k; mac = m; pc = rnd[22:0]; ea = corner ? 16'hFFFF : r2[31:16];
    tpage = rnd[30:23]; vpage = r2[7:0]; ve = r2[8]; byte_op = r2[9]; sh = r2[10];
    rep = r2[11]; edg = r2[12]; xok = r2[13]; yok = r2[14]; wdata = r2[15:0] ^ rnd[15:0];
    salt = rnd[7:0]; x_ea = {4'h0, r2[27:17], 1'b0}; y_ea = {4'h0, rnd[11:1], 1'b0};
    if (m) ea[15] = 1'b0;
    win = (k == ACC_DATA) && ea[15] && ve;
    tw = (k == ACC_TWR_LO) || (k == ACC_TWR_HI);
    tr = (k == ACC_TRD_LO) || (k == ACC_TRD_HI);
    if (k == ACC_FETCH) maddr = {1'b0, pc[22:1], 1'b0};
    else if (win) maddr = {1'b0, vpage, ea[14:0]};
    else maddr = {tpage, ea};
    // sometimes freeze the request edge; nothing may move while ce is low
    if (rnd[31]) begin
      ce = 1'b0;
      @(posedge clk);
      #1;
      chk(paddr_v | rdata_v | fw_req | y_read, 1'b0);
      ce = 1'b1;
    end
    @(posedge clk);
    #1;
    req = 1'b0;
    chk(paddr_v, (k != ACC_DATA) || win);
    if (k == ACC_FETCH) chk(paddr, maddr);
    chk(addr_err, 1'b0);
    if (tr || tw) chk(paddr, maddr);
    if (win) chk(paddr, maddr);
    if (win) chk(paddr[23], 1'b0);
    chk(rdata_v, tr || k == ACC_DATA);
    if (tr) chk(rdata, lane(k == ACC_TRD_HI, byte_op, ea[0], pword));
    if (win) chk(rdata, pword[15:0]);
    if (k == ACC_DATA && !win && !m)
      chk(rdata, (ea > (RAM_END | 16'h0001)) ? 16'h0000 : x_rdata);
    chk(y_read, m);
    if (m) chk(x_out, (xok && x_ea < Y_BASE) ? x_rdata : 16'h0000);
    if (m)
      chk(y_out, (yok && y_ea >= Y_BASE && y_ea <= Y_END) ? y_rdata : 16'h0000);
    chk(fw_req, tw);
    if (tw) chk(fw_high, k == ACC_TWR_HI);
    if (tw) chk(fw_addr, maddr);
    if (tw) chk(fw_data, wdata);
    n = 0;
    while (stall === 1'b1 && n < 4) begin
      n++;
      @(posedge clk);
      #1;
    end
    chk(n, !win ? 0 : (!rep ? (sh ? 1 : 2) : (edg ? 2 : 1)));
  endtask : run_one

  // hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      errors++;
      end_of_test();
    end
  end

  initial begin
    repeat (2) @(posedge clk);
    #1;
    chk(paddr_v | rdata_v | stall | fw_req, 1'b0);
    resetn = 1'b1;
    for (int t = 0; t < 7; t++) begin
      for (int i = 0; i < 40; i++) run_one(t == 6 ? ACC_DATA : kinds[t], t == 6, i == 0);
      $display("test %0d done", t);
    end
    end_of_test();
  end
endmodule : test_program_data_space_mapper
